/* File: shared/fskhi_pkg.sv */
// Constants and types of the FSK modem host register interface
package fskhi_pkg;
    // ==========================================
    // Register selects
    localparam logic [1:0] SEL_DATA = 2'h0;
    localparam logic [1:0] SEL_CMD = 2'h1;
    localparam logic [1:0] SEL_CTRL = 2'h2;
    localparam logic [1:0] SEL_MODE = 2'h3;
    // ==========================================
    // Command fields
    localparam int CMD_ACQUIRE_SYMBOL_TIMING = 7;
    localparam int CMD_ACQUIRE_SIGNAL_LEVELS = 6;
    localparam int CMD_CRC = 5;
    localparam int CMD_IMP = 4;
    localparam logic [2:0] TASK_NULL = 3'h0;
    localparam logic [2:0] TASK_SEND_24_RAW_SYMBOLS_SFSH = 3'h1;
    localparam logic [2:0] TASK_HDR = 3'h2;
    localparam logic [2:0] TASK_MID = 3'h3;
    localparam logic [2:0] TASK_LAST_SFS = 3'h4;
    localparam logic [2:0] TASK_4S = 3'h5;
    localparam logic [2:0] TASK_NULL6 = 3'h6;
    localparam logic [2:0] TASK_RESET = 3'h7;
    // ==========================================
    // Status, mode and control fields
    localparam int ST_BUFFER_FREE_FLAG = 7;
    localparam int ST_IRQ = 6;
    localparam int ST_CRCERR = 5;
    localparam int MODE_INTERRUPT_ENABLE_BIT = 7;
    localparam int MODE_TX = 6;
    localparam int CTL_BW_LSB = 0;
    localparam int CTL_LEV_LSB = 2;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ==========================================
    // Sizes and timing
    localparam logic [3:0] BUF_LAST = 4'hb;
    localparam logic [6:0] BLK_SYMS = 7'h40;
    localparam logic [15:0] CRC_ONES = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam int CLK_HZ = 200000000;
    localparam int SYM_RATE_HZ = 4800;
    localparam int SYM_CYC_DEF = CLK_HZ / SYM_RATE_HZ;
    // ==========================================
    // Symbol levels, zero is the bias level
    localparam logic [2:0] LVL_P3 = 3'h3;
    localparam logic [2:0] LVL_P1 = 3'h1;
    localparam logic [2:0] LVL_M1 = 3'h7;
    localparam logic [2:0] LVL_M3 = 3'h5;
    localparam logic [2:0] LVL_BIAS = 3'h0;
    typedef enum logic [5:0] {
        S_IDLE = 6'h01, S_LOAD = 6'h02, S_ENC = 6'h04,
        S_SEND = 6'h08, S_COLL = 6'h10, S_DEC = 6'h20
    } fskhi_state_e;
endpackage

/* File: verilog/fskhi_host_port.sv */
// Host register port and task engine of the FSK modem
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Bit pairs map 11,10,00,01 to +3,+1,-1,-3
// - Raw tasks send bits 7..6 first
// - Block tasks code three bits per symbol pair
// - Header own checksum, payload checksum at end
// - Four write registers, three read registers
// - Two selects choose buffer, command, control, mode
// - Twelve byte buffer behind one location
// - Pointer steps per access from byte zero
// - Receive works without host reading buffer
// - Command write launches task with qualifiers
// - Idle transmit drives bias level
// - Idle receive keeps filling symbol buffer
// - Bit 7 starts timing acquisition in receive
// - Each bit 7 write in receive restarts timing acquisition, except with task 7
// - Bit 6 starts level acquisition in receive
// - Each bit 6 write in receive restarts level acquisition, except with task 7
// - Transmit block: checksum, code, interleave
// - Receive block: deinterleave, decode, check
// - Task in bits 2..0, 0 none, 7 cancel
// - Task clears free flag, completion sets flags
module fskhi_host_port
    import fskhi_pkg::*;
#(
    parameter int SYM_CYCLES = SYM_CYC_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic reg_select_lo,
    input wire logic reg_select_hi,
    input wire logic [7:0] d_in,
    output logic [7:0] d_out,
    output logic d_oe,
    output logic irq_n,
    output logic [2:0] tx_analog_out,
    output logic tx_pulse_shape_sel,
    input wire logic [2:0] rx_analog_in,
    input wire logic rx_sym_strobe,
    input wire logic [7:0] quality_in,
    output logic [1:0] timing_loop_bandwidth,
    output logic [1:0] level_response_time,
    output logic acquire_symbol_timing,
    output logic acquire_signal_levels
);
    // ==========================================
    // Helpers
    function automatic logic [2:0] bits2lvl(input logic [1:0] b);
        case (b)
            2'h3: bits2lvl = LVL_P3;
            2'h2: bits2lvl = LVL_P1;
            2'h0: bits2lvl = LVL_M1;
            default: bits2lvl = LVL_M3;
        endcase
    endfunction
    function automatic logic [1:0] lvl2bits(input logic [2:0] l);
        case (l)
            LVL_P3: lvl2bits = 2'h3;
            LVL_P1: lvl2bits = 2'h2;
            LVL_M1: lvl2bits = 2'h0;
            default: lvl2bits = 2'h1;
        endcase
    endfunction
    function automatic logic [5:0] ilv(input logic [5:0] i);
        ilv = {i[2:0], i[5:3]};
    endfunction
    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int k = 7; k >= 0; k--) begin
            r = (r[15] ^ b[k]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        crc_byte = r;
    endfunction
    // ==========================================
    // Registers
    fskhi_state_e state_reg;
    logic [7:0] buf_reg [12];
    logic [1:0] sym_mem [64];
    logic [3:0] ptr_reg, ld_idx, ld_last;
    logic [6:0] nsym_reg, tx_idx, rx_wr_idx;
    logic [2:0] task_reg;
    logic [95:0] blk_bits, dec_sr, enc_full, dec_bits;
    logic [15:0] crc_reg, payload_checksum_reg;
    logic [31:0] tmr_reg;
    logic [7:0] ctrl_reg, mode_reg;
    logic buffer_free_flag_reg, irq_reg, crcerr_reg, wr_n_q, rd_n_q, blk_reg;
    logic wr_edge, rd_edge, cmd_wr, task_start, is_tx, done_pulse;
    logic [1:0] sel;
    assign sel = {reg_select_hi, reg_select_lo};
    assign wr_edge = !cs_n && !wr_n && wr_n_q;
    assign rd_edge = !cs_n && !rd_n && rd_n_q;
    assign is_tx = mode_reg[MODE_TX];
    assign cmd_wr = wr_edge && (sel == SEL_CMD);
    assign task_start = cmd_wr && (state_reg == S_IDLE)
        && (d_in[2:0] != TASK_NULL) && (d_in[2:0] != TASK_NULL6)
        && (d_in[2:0] != TASK_RESET);
    assign done_pulse = (state_reg == S_LOAD && ld_idx == ld_last)
        || (state_reg == S_DEC && ld_idx == ld_last);
    assign d_oe = !cs_n && !rd_n;
    assign irq_n = !(irq_reg && mode_reg[MODE_INTERRUPT_ENABLE_BIT]);
    assign timing_loop_bandwidth = ctrl_reg[CTL_BW_LSB +: 2];
    assign level_response_time = ctrl_reg[CTL_LEV_LSB +: 2];
    // ==========================================
    // FEC coding and interleave
    generate
        for (genvar j = 0; j < 32; j++) begin : g_fec
            logic [1:0] s1;
            assign s1 = sym_mem[ilv(6'(2*j + 1))];
            assign dec_bits[95 - 3*j -: 3] =
                {sym_mem[ilv(6'(2*j))], s1[1]};
        end
    endgenerate
    assign enc_full = blk_reg ? blk_bits : {blk_bits[79:0], crc_reg};
    // ==========================================
    // Bus strobes and configuration
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            ctrl_reg <= REG_RESET;
            mode_reg <= REG_RESET;
            tx_pulse_shape_sel <= 1'b0;
        end else begin
            wr_n_q <= cs_n | wr_n;
            rd_n_q <= cs_n | rd_n;
            if (wr_edge && sel == SEL_CTRL) begin
                ctrl_reg <= d_in;
            end
            if (wr_edge && sel == SEL_MODE) begin
                mode_reg <= d_in;
            end
            if (cmd_wr) begin
                tx_pulse_shape_sel <= d_in[CMD_IMP];
            end
        end
    end
    // ==========================================
    // Acquisition restarts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acquire_symbol_timing <= 1'b0;
            acquire_signal_levels <= 1'b0;
        end else begin
            acquire_symbol_timing <= cmd_wr && !is_tx
                && d_in[CMD_ACQUIRE_SYMBOL_TIMING] && (d_in[2:0] != TASK_RESET);
            acquire_signal_levels <= cmd_wr && !is_tx
                && d_in[CMD_ACQUIRE_SIGNAL_LEVELS] && (d_in[2:0] != TASK_RESET);
        end
    end
    // ==========================================
    // Read data and status flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            d_out <= 8'h00;
            buffer_free_flag_reg <= 1'b1;
            irq_reg <= 1'b0;
        end else begin
            if (rd_edge) begin
                case (sel)
                    SEL_DATA: d_out <= buf_reg[ptr_reg];
                    SEL_CMD: d_out <= {buffer_free_flag_reg, irq_reg, crcerr_reg,
                                       5'h00};
                    SEL_CTRL: d_out <= quality_in;
                    default: d_out <= 8'h00;
                endcase
            end
            if (done_pulse || (cmd_wr && d_in[2:0] == TASK_RESET)) begin
                buffer_free_flag_reg <= 1'b1;
            end else if (task_start) begin
                buffer_free_flag_reg <= 1'b0;
            end
            if (done_pulse) begin
                irq_reg <= 1'b1;
            end else if (rd_edge && sel == SEL_CMD) begin
                irq_reg <= 1'b0;
            end
        end
    end
    // ==========================================
    // Buffer pointer and buffer storage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ptr_reg <= 4'h0;
        end else if (task_start || done_pulse || cmd_wr) begin
            ptr_reg <= 4'h0;
        end else if (sel == SEL_DATA && (wr_edge || rd_edge)) begin
            ptr_reg <= (ptr_reg == BUF_LAST) ? 4'h0 : ptr_reg + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (wr_edge && sel == SEL_DATA) begin
            buf_reg[ptr_reg] <= d_in;
        end else if (state_reg == S_DEC) begin
            buf_reg[ld_idx] <= blk_reg ? dec_sr[95:88] : {
                sym_mem[0], sym_mem[1], sym_mem[2], sym_mem[3]};
        end
    end
    // ==========================================
    // Symbol buffer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_wr_idx <= 7'h00;
        end else if (task_start) begin
            rx_wr_idx <= 7'h00;
        end else if (!is_tx && rx_sym_strobe) begin
            rx_wr_idx <= rx_wr_idx + 7'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (!is_tx && rx_sym_strobe) begin
            sym_mem[rx_wr_idx[5:0]] <= lvl2bits(rx_analog_in);
        end else if (state_reg == S_LOAD && nsym_reg != BLK_SYMS) begin
            for (int k = 0; k < 4; k++) begin
                sym_mem[{ld_idx[3:0], 2'(k)}] <= buf_reg[ld_idx][7-2*k -: 2];
            end
        end else if (state_reg == S_ENC) begin
            for (int j = 0; j < 32; j++) begin
                sym_mem[ilv(6'(2*j))] <= enc_full[95 - 3*j -: 2];
                sym_mem[ilv(6'(2*j + 1))] <= {enc_full[95 - 3*j - 2],
                    ^enc_full[95 - 3*j -: 3]};
            end
        end
    end
    // ==========================================
    // Task engine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= S_IDLE;
            ld_idx <= 4'h0;
            ld_last <= 4'h0;
            nsym_reg <= 7'h00;
            tx_idx <= 7'h00;
            task_reg <= TASK_NULL;
            blk_reg <= 1'b0;
            blk_bits <= '0;
            dec_sr <= '0;
            crc_reg <= CRC_ONES;
            payload_checksum_reg <= CRC_ONES;
            crcerr_reg <= 1'b0;
            tmr_reg <= 32'h0;
        end else if (cmd_wr && d_in[2:0] == TASK_RESET) begin
            state_reg <= S_IDLE;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    ld_idx <= 4'h0;
                    tx_idx <= 7'h00;
                    tmr_reg <= 32'h0;
                    if (task_start) begin
                        task_reg <= d_in[2:0];
                        blk_reg <= d_in[2:0] == TASK_MID;
                        if (d_in[2:0] == TASK_HDR || (!is_tx
                            && d_in[2:0] == TASK_SEND_24_RAW_SYMBOLS_SFSH)) begin
                            crc_reg <= d_in[CMD_CRC] ? 16'h0000 : CRC_ONES;
                            payload_checksum_reg <= d_in[CMD_CRC] ? 16'h0000 : CRC_ONES;
                        end else begin
                            crc_reg <= payload_checksum_reg;
                        end
                        case (d_in[2:0])
                            TASK_SEND_24_RAW_SYMBOLS_SFSH: ld_last <= is_tx ? 4'h5 : 4'hb;
                            TASK_MID: ld_last <= 4'hb;
                            TASK_4S: ld_last <= 4'h0;
                            default: ld_last <= is_tx ? 4'h9 : 4'hb;
                        endcase
                        if (is_tx) begin
                            nsym_reg <= (d_in[2:0] == TASK_4S) ? 7'h04 :
                                (d_in[2:0] == TASK_SEND_24_RAW_SYMBOLS_SFSH) ? 7'h18
                                : BLK_SYMS;
                            state_reg <= S_LOAD;
                        end else begin
                            nsym_reg <= (d_in[2:0] == TASK_4S) ? 7'h04 :
                                (d_in[2:0] == TASK_LAST_SFS) ? 7'h00
                                : BLK_SYMS;
                            state_reg <= S_COLL;
                        end
                    end
                end
                S_LOAD: begin
                    blk_bits <= {blk_bits[87:0], buf_reg[ld_idx]};
                    crc_reg <= crc_byte(crc_reg, buf_reg[ld_idx]);
                    ld_idx <= ld_idx + 4'h1;
                    if (ld_idx == ld_last) begin
                        state_reg <= (nsym_reg == BLK_SYMS) ? S_ENC
                            : S_SEND;
                    end
                end
                S_ENC: begin
                    payload_checksum_reg <= crc_reg;
                    state_reg <= S_SEND;
                end
                S_SEND: begin
                    tmr_reg <= (tmr_reg == 32'(SYM_CYCLES - 1)) ? 32'h0
                        : tmr_reg + 32'h1;
                    if (tmr_reg == 32'(SYM_CYCLES - 1)) begin
                        tx_idx <= tx_idx + 7'h01;
                        if (tx_idx == nsym_reg - 7'h01) begin
                            state_reg <= S_IDLE;
                        end
                    end
                end
                S_COLL: begin
                    dec_sr <= dec_bits;
                    ld_idx <= 4'h0;
                    blk_reg <= nsym_reg == BLK_SYMS;
                    if (rx_wr_idx >= nsym_reg) begin
                        state_reg <= S_DEC;
                    end
                end
                S_DEC: begin
                    dec_sr <= {dec_sr[87:0], 8'h00};
                    crc_reg <= crc_byte(crc_reg, dec_sr[95:88]);
                    ld_idx <= ld_idx + 4'h1;
                    if (ld_idx == ld_last) begin
                        crcerr_reg <= blk_reg
                            && crc_byte(crc_reg, dec_sr[95:88]) != 16'h0;
                        payload_checksum_reg <= crc_byte(crc_reg, dec_sr[95:88]);
                        state_reg <= S_IDLE;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
    // ==========================================
    // Transmit level output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_analog_out <= LVL_BIAS;
        end else if (state_reg == S_SEND && is_tx) begin
            tx_analog_out <= bits2lvl(sym_mem[tx_idx[5:0]]);
        end else begin
            tx_analog_out <= LVL_BIAS;
        end
    end
    // ==========================================
    // Checks
    a_free_clear: assert property (@(posedge clk) disable iff (rst)
        task_start |=> !buffer_free_flag_reg) else $error("free flag not cleared");
    a_done_flags: assert property (@(posedge clk) disable iff (rst)
        done_pulse |=> buffer_free_flag_reg && irq_reg) else $error("flags not set");
    a_idle_bias: assert property (@(posedge clk) disable iff (rst)
        (state_reg == S_IDLE) |=> tx_analog_out == LVL_BIAS)
        else $error("idle output not bias");
    a_ptr_step: assert property (@(posedge clk) disable iff (rst)
        (wr_edge && sel == SEL_DATA && ptr_reg < BUF_LAST)
        |=> ptr_reg == $past(ptr_reg) + 4'h1) else $error("pointer stuck");
    a_timing_acq: assert property (@(posedge clk) disable iff (rst)
        (cmd_wr && !is_tx && d_in[7] && d_in[2:0] != TASK_RESET)
        |=> acquire_symbol_timing) else $error("no timing acquire");
    a_timing_tx: assert property (@(posedge clk) disable iff (rst)
        (cmd_wr && is_tx) |=> !acquire_symbol_timing)
        else $error("timing acquire in transmit");
    a_level_acq: assert property (@(posedge clk) disable iff (rst)
        (cmd_wr && !is_tx && d_in[6] && d_in[2:0] != TASK_RESET)
        |=> acquire_signal_levels) else $error("no level acquire");
    a_unused_rd: assert property (@(posedge clk) disable iff (rst)
        (rd_edge && sel == SEL_MODE && !done_pulse) |=> d_out == 8'h00
        && ptr_reg == $past(ptr_reg)) else $error("select 3 read wrong");
    a_task_go: assert property (@(posedge clk) disable iff (rst)
        (task_start && is_tx) |=> state_reg == S_LOAD)
        else $error("transmit task not launched");
endmodule
`default_nettype wire

/* File: test/fskhi_host_model.sv */
// Host microcontroller model driving the modem register port
`timescale 1ns/10ps
`default_nettype none
module fskhi_host_model (
    input wire logic clk,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic reg_select_lo,
    output logic reg_select_hi,
    output logic [7:0] d_in,
    input wire logic [7:0] d_out
);
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        {reg_select_hi, reg_select_lo} = 2'h0;
        d_in = 8'h00;
    end
    // ==========================================
    // Bus cycles
    task automatic wr(input logic [1:0] sel, input logic [7:0] data);
        @(posedge clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        {reg_select_hi, reg_select_lo} <= sel;
        d_in <= (sel == 2'h1) ? (data & 8'hf7) : data;
        @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        d_in <= ~d_in;
        @(posedge clk);
    endtask
    task automatic rd(input logic [1:0] sel, output logic [7:0] data);
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        {reg_select_hi, reg_select_lo} <= sel;
        @(posedge clk);
        @(posedge clk);
        data = d_out;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        @(posedge clk);
    endtask
    task automatic wait_free(output logic ok);
        logic [7:0] s;
        ok = 1'b0;
        for (int i = 0; i < 400 && !ok; i++) begin
            rd(2'h1, s);
            ok = s[7];
        end
    endtask
endmodule
`default_nettype wire

/* File: test/test_fsk_modem_host_register_interface.sv */
// Self-checking testbench of the FSK modem host register port
`timescale 1ns/10ps
`default_nettype none
module test_fsk_modem_host_register_interface;
    import fskhi_pkg::*;
    typedef struct packed {logic [1:0] sel; logic [7:0] exp;} fskhi_row_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cs_n, rd_n, wr_n, sel_lo, sel_hi, d_oe, irq_n, shape, aqs, aql, ok;
    logic rx_strobe = 1'b0;
    logic [7:0] d_in, d_out, rdata;
    logic [7:0] quality_in = 8'h5a;
    logic [2:0] tx_out;
    logic [2:0] rx_in = 3'h0;
    logic [1:0] bw, lev;
    int n_errors = 0;
    int cmp_count = 0;
    int n_aqs = 0;
    int n_aql = 0;
    int k;
    fskhi_row_s rows [5] = '{'{SEL_CMD, 8'h80}, '{SEL_CTRL, 8'h5a},
        '{SEL_MODE, 8'h00}, '{SEL_MODE, 8'h00}, '{SEL_CMD, 8'h80}};
    logic [2:0] tx_exp [4] = '{LVL_P1, LVL_P3, LVL_M3, LVL_M1};
    logic [2:0] rx_syms [4] = '{LVL_P3, LVL_M1, LVL_P1, LVL_M3};

    always #2.5 clk = ~clk;

    fskhi_host_port #(.SYM_CYCLES(4)) uut (.clk(clk), .rst(rst),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .reg_select_lo(sel_lo),
        .reg_select_hi(sel_hi), .d_in(d_in), .d_out(d_out), .d_oe(d_oe),
        .irq_n(irq_n), .tx_analog_out(tx_out), .tx_pulse_shape_sel(shape),
        .rx_analog_in(rx_in), .rx_sym_strobe(rx_strobe),
        .quality_in(quality_in), .timing_loop_bandwidth(bw),
        .level_response_time(lev), .acquire_symbol_timing(aqs),
        .acquire_signal_levels(aql));
    fskhi_host_model host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .reg_select_lo(sel_lo), .reg_select_hi(sel_hi),
        .d_in(d_in), .d_out(d_out));

    always @(negedge clk) begin
        if (aqs === 1'b1) n_aqs <= n_aqs + 1;
        if (aql === 1'b1) n_aql <= n_aql + 1;
    end
    // ==========================================
    // Compare and verdict
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({5'h00, tx_out}, {5'h00, LVL_BIAS});
        chk({7'h00, irq_n}, 8'h01);
        chk({7'h00, d_oe}, 8'h00);
        foreach (rows[i]) begin
            host.rd(rows[i].sel, rdata);
            chk(rdata, rows[i].exp);
        end
        host.wr(SEL_CTRL, 8'h0e);
        chk({4'h0, lev, bw}, 8'h0e);
        host.wr(SEL_CMD, 8'hc5);
        chk(8'(n_aqs), 8'h01);
        chk(8'(n_aql), 8'h01);
        foreach (rx_syms[i]) begin
            @(posedge clk);
            rx_in <= rx_syms[i];
            rx_strobe <= 1'b1;
            @(posedge clk);
            rx_strobe <= 1'b0;
        end
        host.wait_free(ok);
        chk({7'h00, ok}, 8'h01);
        host.rd(SEL_DATA, rdata);
        chk(rdata, 8'hc9);
        host.wr(SEL_CMD, 8'hc0);
        host.wr(SEL_CMD, 8'hc7);
        chk(8'(n_aqs), 8'h02);
        chk(8'(n_aql), 8'h02);
        host.wr(SEL_MODE, 8'hc0);
        host.wr(SEL_CMD, 8'hc0);
        chk(8'(n_aqs), 8'h02);
        host.wr(SEL_DATA, 8'hb4);
        host.wr(SEL_CMD, {3'h0, 1'b1, 1'b0, TASK_4S});
        chk({7'h00, shape}, 8'h01);
        for (k = 0; k < 200 && tx_out === LVL_BIAS; k++) @(posedge clk);
        repeat (2) @(posedge clk);
        foreach (tx_exp[i]) begin
            chk({5'h00, tx_out}, {5'h00, tx_exp[i]});
            repeat (4) @(posedge clk);
        end
        chk({5'h00, tx_out}, {5'h00, LVL_BIAS});
        chk({7'h00, irq_n}, 8'h00);
        host.rd(SEL_CMD, rdata);
        chk(rdata & 8'hc0, 8'hc0);
        host.rd(SEL_CMD, rdata);
        chk(rdata & 8'hc0, 8'h80);
        // preamble of +3 +3 -3 -3 from six bytes
        host.wait_free(ok);
        chk({7'h00, ok}, 8'h01);
        for (k = 0; k < 6; k++) begin
            host.wr(SEL_DATA, 8'hf5);
        end
        host.wr(SEL_CMD, {5'h00, TASK_SEND_24_RAW_SYMBOLS_SFSH});
        for (k = 0; k < 200 && tx_out === LVL_BIAS; k++) @(posedge clk);
        repeat (2) @(posedge clk);
        for (k = 0; k < 24; k++) begin
            chk({5'h00, tx_out}, {5'h00, k[1] ? LVL_M3 : LVL_P3});
            repeat (4) @(posedge clk);
        end
        chk({5'h00, tx_out}, {5'h00, LVL_BIAS});
        // Receive one block of +3 symbols, every triple decodes to ones
        host.wr(SEL_MODE, 8'h80);
        host.wr(SEL_CMD, {5'h00, TASK_MID});
        for (k = 0; k < 64; k++) begin
            @(posedge clk);
            rx_in <= LVL_P3;
            rx_strobe <= 1'b1;
            @(posedge clk);
            rx_strobe <= 1'b0;
        end
        host.wait_free(ok);
        chk({7'h00, ok}, 8'h01);
        // host counts blocks, reads all twelve bytes
        for (k = 0; k < 12; k++) begin
            host.rd(SEL_DATA, rdata);
            chk(rdata, 8'hff);
        end
        results;
    end
    // Watchdog well past the few hundred cycles the tests need
    initial begin
        #100000;
        n_errors++;
        results;
    end
endmodule
`default_nettype wire
